// ===== rtl/dspp_pkg.sv
package dspp_pkg;
    // register map of the two ports
    localparam logic [7:0] ADDR_CTL_A = 8'h0a;
    localparam logic [7:0] ADDR_STS_A = 8'h0b;
    localparam logic [7:0] ADDR_DAT_A = 8'h0c;
    localparam logic [7:0] ADDR_CTL_B = 8'h0d;
    localparam logic [7:0] ADDR_STS_B = 8'h0e;
    localparam logic [7:0] ADDR_DAT_B = 8'h0f;
    // control field positions
    localparam int CTL_IRQ_EN = 7;
    localparam int CTL_PORT_ON = 6;
    localparam int CTL_ORDER = 5;
    localparam int CTL_ROLE = 4;
    localparam int CTL_RATE = 0;
    localparam logic [7:0] CTL_WMASK = 8'hf1;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // status field positions
    localparam int STS_DONE = 7;
    localparam int STS_COLL = 6;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // serial clock divisors of the processor clock
    localparam int DIV_FAST = 2;
    localparam int DIV_SLOW = 16;
    localparam logic [3:0] RELOAD_FAST = 4'(DIV_FAST / 2 - 1);
    localparam logic [3:0] RELOAD_SLOW = 4'(DIV_SLOW / 2 - 1);
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {DSPP_SEL_CTL, DSPP_SEL_STS, DSPP_SEL_DAT, DSPP_SEL_NONE} dspp_sel_e;

    typedef struct packed {
        logic wr;
        logic rd;
        dspp_sel_e sel;
        logic [7:0] wdata;
    } dspp_acc_s;

    typedef struct packed {
        logic takeover;
        logic sclk_out;
        logic sclk_oe;
        logic sdo_out;
        logic sdo_oe;
    } dspp_pin_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dspp_rx_s;
endpackage : dspp_pkg

// ===== rtl/dspp_top.sv
// Function
// RL1 - two independent ports, each with own registers and pins
// RL2 - port on takes lowest three pins as serial in, out and clock
// RL3 - clock pin driven in master role, input in slave role
// RL4 - order bit set shifts lsb first, clear shifts msb first
// RL5 - master write to shift data starts transfer and clock; here dropped while the receive fifo is full
// RL6 - input bits shift in while output bits shift out
// RL7 - after eight bits the clock stops and done flag sets
// RL8 - done flag with interrupt enable raises interrupt request; here a master port raises none in stop mode
// RL9 - slave completes in stop mode and its interrupt wakes device
// RL10 - writes to shift data ignored while done flag is one; here taken once a status read with done set has armed the clear
// RL11 - rate bit sets master clock; slave uses pin clock only
// RL12 - three-bit pulse counter overflow sets done flag
// RL13 - output changes on falling edge, input sampled on rising edge
// RL14 - received byte replaces sent byte; one completion flag only
// RL15 - outside logic should hold clock line high before port on
// RL16 - one byte per transfer over exactly eight master pulses
// RL17 - master bit rate at most half the processor clock
// RL18 - external master clock no faster than processor clock
// RL19 - rate zero divides by two, rate one divides by sixteen
// RL20 - data access while busy sets collision, write dropped, no interrupt
// RL21 - status read with done set then data access clears both flags
// RL22 - port off resets control logic and releases pins
// RL23 - master holds clock high while idle
`timescale 1ns/100ps

module dspp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_idx_reg;
    logic [AW-1:0] rd_idx_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // output stage counts toward the depth
    assign in_ready = (count_reg + (AW+1)'(out_valid)) != (AW+1)'(DEPTH);
    assign push = in_valid && in_ready;
    assign pop = (count_reg != '0) && (!out_valid || out_ready);

    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_idx_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_idx_reg <= (wr_idx_reg == AW'(DEPTH - 1)) ? '0 : wr_idx_reg + 1'b1;
            end
            if (pop) begin
                rd_idx_reg <= (rd_idx_reg == AW'(DEPTH - 1)) ? '0 : rd_idx_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output stage so the consumer sees flops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem_reg[rd_idx_reg];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : dspp_fifo

module dspp_port (
    input wire logic clock,
    input wire logic rst,
    input dspp_pkg::dspp_acc_s acc,
    output logic [7:0] rdata,
    input wire logic stop_mode,
    input wire logic sdi_pin,
    input wire logic sclk_pin,
    output dspp_pkg::dspp_pin_s pins,
    output logic irq,
    output dspp_pkg::dspp_rx_s rx,
    input wire logic rx_ready
);
    logic [7:0] ctl_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_reg;
    logic done_reg;
    logic coll_reg;
    logic armed_reg;
    logic busy_reg;
    logic run_reg;
    logic sclk_reg;
    logic sdo_reg;
    logic sclk_oe_reg;
    logic sdo_oe_reg;
    logic take_reg;
    logic irq_reg;
    logic [2:0] tx_cnt_reg;
    logic [2:0] rx_cnt_reg;
    logic [3:0] half_cnt_reg;
    logic [1:0] rise_pipe_reg;
    logic [2:0] sdi_sync_reg;
    logic [2:0] sck_sync_reg;
    logic [7:0] rx_next;
    logic on;
    logic master;
    logic lsb_first;
    logic dat_acc;
    logic wr_ok;
    logic start;
    logic m_tick;
    logic m_fall;
    logic m_rise;
    logic s_fall;
    logic s_rise;
    logic fall_ev;
    logic samp_ev;
    logic set_done;
    logic fifo_ready;

    assign on = ctl_reg[dspp_pkg::CTL_PORT_ON];
    assign master = ctl_reg[dspp_pkg::CTL_ROLE];
    assign lsb_first = ctl_reg[dspp_pkg::CTL_ORDER];
    assign dat_acc = (acc.wr || acc.rd) && acc.sel == dspp_pkg::DSPP_SEL_DAT;
    assign wr_ok = acc.wr && acc.sel == dspp_pkg::DSPP_SEL_DAT && !busy_reg
        && (!done_reg || armed_reg) && (fifo_ready || !(on && master)); // RL10 RL20
    assign start = wr_ok && on && master; // RL5
    assign m_tick = on && master && run_reg && half_cnt_reg == 4'h0;
    assign m_fall = m_tick && sclk_reg;
    assign m_rise = m_tick && !sclk_reg;
    // edge detect looks only past the first sync stage
    assign s_fall = on && !master && !done_reg && sck_sync_reg[2] && !sck_sync_reg[1]; // RL11
    assign s_rise = on && !master && busy_reg && !sck_sync_reg[2] && sck_sync_reg[1];
    assign fall_ev = m_fall || s_fall; // RL13
    assign samp_ev = (master ? rise_pipe_reg[1] : s_rise) && busy_reg; // RL13
    assign set_done = samp_ev && rx_cnt_reg == dspp_pkg::LAST_BIT; // RL12 RL16

    always_comb begin
        rx_next = rx_reg;
        rx_next[lsb_first ? rx_cnt_reg : 3'(3'h7 - rx_cnt_reg)] = sdi_sync_reg[1]; // RL4 RL6
    end

    always_comb begin
        unique case (acc.sel)
            dspp_pkg::DSPP_SEL_CTL: rdata = ctl_reg;
            dspp_pkg::DSPP_SEL_STS: rdata = {done_reg, coll_reg, 6'h00}; // RL14
            dspp_pkg::DSPP_SEL_DAT: rdata = shift_reg;
            dspp_pkg::DSPP_SEL_NONE: rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sdi_sync_reg <= 3'h0;
            sck_sync_reg <= 3'h7;
        end else begin
            sdi_sync_reg <= {sdi_sync_reg[1:0], sdi_pin};
            sck_sync_reg <= {sck_sync_reg[1:0], sclk_pin};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl_reg <= dspp_pkg::CTL_RESET;
        end else if (acc.wr && acc.sel == dspp_pkg::DSPP_SEL_CTL) begin
            ctl_reg <= acc.wdata & dspp_pkg::CTL_WMASK;
        end
    end

    // flags: a set in the same cycle as a clear wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_reg <= 1'b0;
            coll_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (!on) begin
            done_reg <= 1'b0; // RL22
            coll_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            if (set_done) begin
                done_reg <= 1'b1; // RL7
            end else if (armed_reg && dat_acc) begin
                done_reg <= 1'b0; // RL21
            end
            if (busy_reg && dat_acc) begin
                coll_reg <= 1'b1; // RL20
            end else if (armed_reg && dat_acc) begin
                coll_reg <= 1'b0; // RL21
            end
            if (acc.rd && acc.sel == dspp_pkg::DSPP_SEL_STS && done_reg) begin
                armed_reg <= 1'b1;
            end else if (dat_acc) begin
                armed_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_reg <= dspp_pkg::DATA_RESET;
        end else if (wr_ok) begin
            shift_reg <= acc.wdata;
        end else if (set_done) begin
            shift_reg <= rx_next; // RL14
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            run_reg <= 1'b0;
            tx_cnt_reg <= 3'h0;
            rx_cnt_reg <= 3'h0;
            rx_reg <= 8'h00;
            rise_pipe_reg <= 2'h0;
        end else if (!on) begin
            busy_reg <= 1'b0; // RL22
            run_reg <= 1'b0;
            tx_cnt_reg <= 3'h0;
            rx_cnt_reg <= 3'h0;
            rise_pipe_reg <= 2'h0;
        end else begin
            // master samples after the input sync delay
            rise_pipe_reg <= {rise_pipe_reg[0], m_rise};
            if (start || s_fall) begin
                busy_reg <= 1'b1;
            end else if (set_done) begin
                busy_reg <= 1'b0;
            end
            if (start) begin
                run_reg <= 1'b1;
            end else if (m_rise && tx_cnt_reg == 3'h0) begin
                run_reg <= 1'b0; // RL7 RL16
            end
            if (fall_ev) begin
                tx_cnt_reg <= tx_cnt_reg + 3'h1;
            end
            if (samp_ev) begin
                rx_cnt_reg <= rx_cnt_reg + 3'h1; // RL12
                rx_reg <= rx_next; // RL6
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            half_cnt_reg <= 4'h0;
            sclk_reg <= 1'b1;
        end else if (!on || !master) begin
            half_cnt_reg <= 4'h0;
            sclk_reg <= 1'b1; // RL23
        end else if (start) begin
            half_cnt_reg <= 4'h0; // RL5
        end else if (m_tick) begin
            half_cnt_reg <= ctl_reg[dspp_pkg::CTL_RATE] ? dspp_pkg::RELOAD_SLOW
                : dspp_pkg::RELOAD_FAST; // RL11 RL17 RL19
            sclk_reg <= !sclk_reg;
        end else if (half_cnt_reg != 4'h0) begin
            half_cnt_reg <= half_cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sdo_reg <= 1'b0;
        end else if (fall_ev) begin
            sdo_reg <= shift_reg[lsb_first ? tx_cnt_reg : 3'(3'h7 - tx_cnt_reg)]; // RL4 RL13
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_oe_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
            take_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            sclk_oe_reg <= on && master; // RL3
            sdo_oe_reg <= on; // RL2
            take_reg <= on; // RL2 RL22
            irq_reg <= done_reg && ctl_reg[dspp_pkg::CTL_IRQ_EN]
                && (!stop_mode || !master); // RL8 RL9
        end
    end

    dspp_fifo #(.WIDTH(dspp_pkg::DATA_W), .DEPTH(dspp_pkg::FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(set_done),
        .in_ready(fifo_ready),
        .in_data(rx_next),
        .out_valid(rx.valid),
        .out_ready(rx_ready),
        .out_data(rx.data)
    );

    assign pins = '{take_reg, sclk_reg, sclk_oe_reg, sdo_reg, sdo_oe_reg};
    assign irq = irq_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_release;
        !on |=> !pins.sclk_oe && !pins.sdo_oe && !pins.takeover;
    endproperty
    a_release: assert property (p_release) else $error("pins not released"); // RL22
    property p_clk_dir;
        on |=> pins.sclk_oe == $past(master);
    endproperty
    a_clk_dir: assert property (p_clk_dir) else $error("clock pin direction wrong"); // RL3
    property p_fast;
        $fell(sclk_reg) && !ctl_reg[dspp_pkg::CTL_RATE] && $stable(ctl_reg) |=> sclk_reg;
    endproperty
    a_fast: assert property (p_fast) else $error("fast half period wrong"); // RL19
    property p_slow;
        $fell(sclk_reg) && ctl_reg[dspp_pkg::CTL_RATE] |-> (!sclk_reg)[*8] ##1 sclk_reg;
    endproperty
    a_slow: assert property (p_slow) else $error("slow half period wrong"); // RL19
    property p_idle_high;
        on && master && !busy_reg |-> sclk_reg;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle clock not high"); // RL23
    property p_start;
        start |=> busy_reg && run_reg ##[1:2] !sclk_reg;
    endproperty
    a_start: assert property (p_start) else $error("write did not start"); // RL5
    property p_ignore;
        done_reg && !armed_reg && acc.wr && acc.sel == dspp_pkg::DSPP_SEL_DAT
            |=> $stable(shift_reg) && !busy_reg;
    endproperty
    a_ignore: assert property (p_ignore) else $error("write taken while done"); // RL10
    property p_coll;
        on && busy_reg && dat_acc |=> coll_reg && (!irq_reg || done_reg);
    endproperty
    a_coll: assert property (p_coll) else $error("collision not flagged"); // RL20
    property p_clear;
        on && armed_reg && dat_acc && !busy_reg |=> !done_reg && !coll_reg;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared"); // RL21
    property p_eight;
        $rose(done_reg) |-> $past(rx_cnt_reg) == dspp_pkg::LAST_BIT && !run_reg && sclk_reg;
    endproperty
    a_eight: assert property (p_eight) else $error("done without eight bits"); // RL12
    property p_irq;
        done_reg && ctl_reg[dspp_pkg::CTL_IRQ_EN] && !master |=> irq_reg;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing"); // RL8
    c_master: cover property (start ##[1:200] $rose(done_reg));
    c_slave: cover property (s_fall && !master ##[1:400] $rose(done_reg));
    c_coll: cover property (busy_reg && dat_acc);
endmodule : dspp_port

module dspp_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic stop_mode,
    input wire logic sdi_a,
    input wire logic sclk_in_a,
    output dspp_pkg::dspp_pin_s pins_a,
    output logic irq_a,
    output dspp_pkg::dspp_rx_s rx_a,
    input wire logic rx_ready_a,
    input wire logic sdi_b,
    input wire logic sclk_in_b,
    output dspp_pkg::dspp_pin_s pins_b,
    output logic irq_b,
    output dspp_pkg::dspp_rx_s rx_b,
    input wire logic rx_ready_b
);
    dspp_pkg::dspp_acc_s acc_a;
    dspp_pkg::dspp_acc_s acc_b;
    logic [7:0] rdata_a;
    logic [7:0] rdata_b;
    logic [7:0] rdata_reg;

    always_comb begin
        acc_a = '{cpu_wr, cpu_rd, dspp_pkg::DSPP_SEL_NONE, cpu_wdata};
        acc_b = '{cpu_wr, cpu_rd, dspp_pkg::DSPP_SEL_NONE, cpu_wdata};
        case (cpu_addr)
            dspp_pkg::ADDR_CTL_A: acc_a.sel = dspp_pkg::DSPP_SEL_CTL;
            dspp_pkg::ADDR_STS_A: acc_a.sel = dspp_pkg::DSPP_SEL_STS;
            dspp_pkg::ADDR_DAT_A: acc_a.sel = dspp_pkg::DSPP_SEL_DAT;
            dspp_pkg::ADDR_CTL_B: acc_b.sel = dspp_pkg::DSPP_SEL_CTL;
            dspp_pkg::ADDR_STS_B: acc_b.sel = dspp_pkg::DSPP_SEL_STS;
            dspp_pkg::ADDR_DAT_B: acc_b.sel = dspp_pkg::DSPP_SEL_DAT;
            default: acc_a.sel = dspp_pkg::DSPP_SEL_NONE;
        endcase
    end

    // unmapped reads return zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (cpu_rd) begin
            rdata_reg <= rdata_a | rdata_b;
        end
    end
    assign cpu_rdata = rdata_reg;

    dspp_port u_port_a ( // RL1
        .clock(clock),
        .rst(rst),
        .acc(acc_a),
        .rdata(rdata_a),
        .stop_mode(stop_mode),
        .sdi_pin(sdi_a),
        .sclk_pin(sclk_in_a),
        .pins(pins_a),
        .irq(irq_a),
        .rx(rx_a),
        .rx_ready(rx_ready_a)
    );

    dspp_port u_port_b ( // RL1
        .clock(clock),
        .rst(rst),
        .acc(acc_b),
        .rdata(rdata_b),
        .stop_mode(stop_mode),
        .sdi_pin(sdi_b),
        .sclk_pin(sclk_in_b),
        .pins(pins_b),
        .irq(irq_b),
        .rx(rx_b),
        .rx_ready(rx_ready_b)
    );
endmodule : dspp_top

// ===== tb/dspp_serial_partner.sv
`timescale 1ns/100ps

module dspp_serial_partner (
    input wire logic clock,
    input wire logic drive_clk,
    input wire logic lsb_first,
    input wire logic [7:0] tx,
    input wire logic start,
    input wire logic [3:0] half,
    input wire logic sclk_dev,
    input wire logic sdo_dev,
    output logic serial_in_pin,
    output logic sclk,
    output logic [7:0] rx,
    output logic [3:0] cnt
);
    logic sclk_r = 1'h1;
    logic line_prev = 1'h1;
    logic line;
    logic [2:0] pos;

    initial begin
        serial_in_pin = 1'h0;
        rx = 8'h00;
        cnt = 4'h8;
    end

    assign line = drive_clk ? sclk_r : sclk_dev;
    assign sclk = sclk_r;
    assign pos = lsb_first ? cnt[2:0] : 3'h7 - cnt[2:0];

    // reacts mid-cycle, as a pin-level device answers well inside a half period
    always @(negedge clock) begin
        line_prev <= line;
        if (start) begin
            cnt <= 4'h0;
        end else if (cnt == 4'h8) begin
            // idle line toggles every cycle: no stale level between frames
            serial_in_pin <= ~serial_in_pin;
        end else if (line_prev && !line) begin
            serial_in_pin <= tx[pos];
        end else if (!line_prev && line) begin
            rx[pos] <= sdo_dev;
            cnt <= cnt + 4'h1;
        end
    end

    always @(posedge clock) begin
        if (start && drive_clk) begin
            repeat (8) begin
                sclk_r <= 1'h0;
                repeat (half) @(posedge clock);
                sclk_r <= 1'h1;
                repeat (half) @(posedge clock);
            end
        end
    end
endmodule : dspp_serial_partner

// ===== tb/tb_dspp_top.sv
`timescale 1ns/100ps

module tb_dspp_top;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [7:0] cpu_addr = 8'h00;
    logic cpu_wr = 1'h0;
    logic cpu_rd = 1'h0;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata;
    logic stop_mode = 1'h0;
    logic sdi_a, sdi_b, psclk_a, psclk_b, sclk_a, sclk_b, irq_a, irq_b;
    dspp_pkg::dspp_pin_s pins_a, pins_b;
    dspp_pkg::dspp_rx_s rx_a, rx_b;
    logic rx_ready_a = 1'h0;
    logic rx_ready_b = 1'h0;
    logic ord_a = 1'h0;
    logic st_a = 1'h0;
    logic st_b = 1'h0;
    logic [7:0] tx_a = 8'h00;
    logic [7:0] tx_b = 8'h00;
    logic [7:0] prx_a, prx_b;
    logic [3:0] cnt_a, cnt_b;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] q[$];

    always #5 clock = ~clock;

    // wire level of the clock pin from both parties
    assign sclk_a = pins_a.sclk_oe ? pins_a.sclk_out : psclk_a;
    assign sclk_b = pins_b.sclk_oe ? pins_b.sclk_out : psclk_b;

    dspp_top i_dspp_top (.clock(clock), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .stop_mode(stop_mode),
        .sdi_a(sdi_a), .sclk_in_a(sclk_a), .pins_a(pins_a), .irq_a(irq_a), .rx_a(rx_a),
        .rx_ready_a(rx_ready_a), .sdi_b(sdi_b), .sclk_in_b(sclk_b), .pins_b(pins_b),
        .irq_b(irq_b), .rx_b(rx_b), .rx_ready_b(rx_ready_b));

    dspp_serial_partner i_dspp_serial_partner_a (.clock(clock), .drive_clk(1'h0),
        .lsb_first(ord_a), .tx(tx_a), .start(st_a), .half(4'h1), .sclk_dev(sclk_a),
        .sdo_dev(pins_a.sdo_out), .serial_in_pin(sdi_a), .sclk(psclk_a), .rx(prx_a), .cnt(cnt_a));

    dspp_serial_partner i_dspp_serial_partner_b (.clock(clock), .drive_clk(1'h1),
        .lsb_first(1'h0), .tx(tx_b), .start(st_b), .half(4'h6), .sclk_dev(sclk_b),
        .sdo_dev(pins_b.sdo_out), .serial_in_pin(sdi_b), .sclk(psclk_b), .rx(prx_b), .cnt(cnt_b));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'h1;
        @(posedge clock);
        cpu_wr <= 1'h0;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        cpu_addr <= a;
        cpu_rd <= 1'h1;
        @(posedge clock);
        cpu_rd <= 1'h0;
        @(posedge clock);
        #1 chk(cpu_rdata, exp);
    endtask : rc

    task automatic kick(input logic b);
        @(posedge clock);
        st_a <= ~b;
        st_b <= b;
        @(posedge clock);
        st_a <= 1'h0;
        st_b <= 1'h0;
    endtask : kick

    task automatic wait_irq(input logic b, output int n);
        n = 0;
        while ((b ? irq_b : irq_a) !== 1'h1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(8'(n < 400), 8'h01);
    endtask : wait_irq

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        int n;
        int h;
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        for (int a = 10; a < 17; a++) begin
            rc(8'(a), 8'h00);
        end
        chk(8'(pins_a), 8'h08);
        wr(dspp_pkg::ADDR_CTL_A, 8'hff);
        rc(dspp_pkg::ADDR_CTL_A, 8'hf1);
        chk(8'(pins_a) & 8'h1d, 8'h1d);
        $display("test reset and control done");

        for (int i = 0; i < 8; i++) begin
            h = i[1] ? 8 : 1;
            ord_a <= i[0];
            tx_a <= 8'h5a ^ 8'(i * 37);
            wr(dspp_pkg::ADDR_CTL_A, {4'hd, 3'h0, i[1]} | (8'(i[0]) << 5));
            kick(1'h0);
            wr(dspp_pkg::ADDR_DAT_A, 8'hc3 + 8'(i));
            wait_irq(1'h0, n);
            chk(8'(n >= 15 * h + 3 && n <= 15 * h + 9), 8'h01);
            rc(dspp_pkg::ADDR_STS_A, 8'h80);
            rc(dspp_pkg::ADDR_DAT_A, tx_a);
            chk(prx_a, 8'hc3 + 8'(i));
            chk(8'(cnt_a), 8'h08);
            rc(dspp_pkg::ADDR_STS_A, 8'h00);
            q.push_back(tx_a);
        end
        chk(8'(rx_a.valid), 8'h01);
        kick(1'h0);
        wr(dspp_pkg::ADDR_DAT_A, 8'h11);
        repeat (40) @(posedge clock);
        chk(8'(cnt_a), 8'h00);
        rc(dspp_pkg::ADDR_STS_A, 8'h00);
        rx_ready_a <= 1'h1;
        n = 0;
        while (q.size() > 0 && n < 100) begin
            @(posedge clock);
            n++;
            if (rx_a.valid === 1'h1) begin
                chk(rx_a.data, q.pop_front());
            end
        end
        chk(8'(q.size()), 8'h00);
        @(posedge clock);
        #1 chk(8'(rx_a.valid), 8'h00);
        $display("test master transfers and fifo done");

        ord_a <= 1'h0;
        tx_a <= 8'h96;
        wr(dspp_pkg::ADDR_CTL_A, 8'hd1);
        kick(1'h0);
        wr(dspp_pkg::ADDR_DAT_A, 8'h3c);
        wr(dspp_pkg::ADDR_DAT_A, 8'hff);
        #1 chk(8'(irq_a), 8'h00);
        wait_irq(1'h0, n);
        kick(1'h0);
        wr(dspp_pkg::ADDR_DAT_A, 8'h77);
        repeat (30) @(posedge clock);
        chk(8'(cnt_a), 8'h00);
        chk(prx_a, 8'h3c);
        rc(dspp_pkg::ADDR_STS_A, 8'hc0);
        rc(dspp_pkg::ADDR_DAT_A, 8'h96);
        rc(dspp_pkg::ADDR_STS_A, 8'h00);
        $display("test collision done");

        tx_b <= 8'hd2;
        wr(dspp_pkg::ADDR_CTL_B, 8'hc1);
        wr(dspp_pkg::ADDR_DAT_B, 8'h4b);
        chk(8'(pins_b) & 8'h15, 8'h11);
        stop_mode <= 1'h1;
        kick(1'h1);
        wait_irq(1'h1, n);
        chk(prx_b, 8'h4b);
        chk(rx_b.data, 8'hd2);
        chk(8'(rx_b.valid), 8'h01);
        rx_ready_b <= 1'h1;
        stop_mode <= 1'h0;
        rc(dspp_pkg::ADDR_STS_B, 8'h80);
        rc(dspp_pkg::ADDR_DAT_B, 8'hd2);
        rc(dspp_pkg::ADDR_STS_A, 8'h00);
        $display("test slave in stop mode done");

        wr(dspp_pkg::ADDR_CTL_A, 8'h00);
        repeat (2) @(posedge clock);
        chk(8'(pins_a) & 8'h1d, 8'h08);
        wr(dspp_pkg::ADDR_DAT_A, 8'ha5);
        rc(dspp_pkg::ADDR_DAT_A, 8'ha5);
        $display("test port off done");
        end_sim();
    end
endmodule : tb_dspp_top
